// ---- adc_control_interface_test.sv ----
// Self-checking bench of the converter control block
module adc_control_interface_test
  import adci_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ns;
  localparam int T = 2;
  logic        pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0;
  logic [11:0] paddr = 0;
  logic [31:0] pwdata = 0, prdata;
  logic [3:0]  pstrb = 4'hF, channel_select, ch;
  logic [5:0]  level = 0, lv;
  logic [9:0]  core_sample;
  logic [7:0]  c;
  logic        pready, pslverr, converter_enable, irq;
  logic [32:0] exp_q[$];
  int          n_fail = 0, total_checks = 0, cyc = 0, seed = 32'h7E67, n, dv;

  adci_top #(.TICKS(T)) adci_top_i (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .core_sample(core_sample), .channel_select(channel_select),
    .converter_enable(converter_enable), .irq(irq));
  adci_core_model adci_core_model_i (.pclk(pclk), .channel_select(channel_select),
    .converter_enable(converter_enable), .level(level), .core_sample(core_sample));

  always #10 pclk = ~pclk;

  task automatic wrap_up();
    $display("Checks %0d, mismatches %0d", total_checks, n_fail);
    if (n_fail == 0 && total_checks > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask

  task automatic chk(input logic [32:0] got, input logic [32:0] exp, input string what);
    total_checks++;
    if (got !== exp) begin
      n_fail++;
      $display("Error at %0t: %s got %h expected %h", $time, what, got, exp);
    end
  endtask

  always @(posedge pclk) begin
    cyc <= cyc + 1;
    if (cyc == 8000) begin
      n_fail++;
      wrap_up();
    end
  end

  // Read results are compared in the access edge, oldest note first
  always @(posedge pclk) begin
    if (psel && penable && pready === 1'b1 && !pwrite) begin
      chk({pslverr, prdata}, exp_q.pop_front(), "read data");
    end
  end

  // Edge first, so psel never falls and rises in one time step
  task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d, input logic [32:0] e);
    @(posedge pclk);
    if (!wr) exp_q.push_back(e);
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do @(posedge pclk); while (pready !== 1'b1);
    psel <= 1'b0;
    penable <= 1'b0;
  endtask

  task automatic wr(input logic [11:0] a, input logic [7:0] d);
    apb(1'b1, a, {24'h0, d}, '0);
  endtask

  task automatic rd(input logic [11:0] a, input logic [7:0] d, input logic err = 1'b0);
    apb(1'b0, a, 32'h0, {err, 24'h0, d});
  endtask

  initial begin
    repeat (10) @(posedge pclk);
    presetn <= 1'b1;
    rd(ADCI_OFF_CONTROL, ADCI_CONTROL_RESET);
    rd(12'h3F0, 8'h00, 1'b1);
    wr(ADCI_OFF_IRQ_MASK, 8'h01);
    for (int k = 0; k < 4; k++) begin
      ch = $random(seed);
      lv = $random(seed);
      level <= lv;
      c = {ch, 1'b0, k[1:0], 1'b1};
      wr(ADCI_OFF_CONTROL, c);
      @(posedge pclk);
      chk({29'h0, channel_select}, {29'h0, ch}, "channel");
      chk({32'h0, converter_enable}, 33'h1, "enable");
      n = 0;
      while (irq !== 1'b1 && n < 600) begin
        @(posedge pclk);
        n++;
      end
      dv = (k == 3) ? 1 : (16 >> k);
      chk({32'h0, n >= (T - 1) * dv && n <= (T + 1) * dv + 6}, 33'h1, "length");
      rd(ADCI_OFF_CONTROL, {ch, 1'b1, k[1:0], 1'b0});
      rd(ADCI_OFF_RESULT_HIGH, {ch, lv[5:2]});
      rd(ADCI_OFF_RESULT_LOW, {6'h0, lv[1:0]});
      wr(ADCI_OFF_RESULT_HIGH, 8'hFF);
      wr(ADCI_OFF_RESULT_LOW, 8'hFF);
      rd(ADCI_OFF_RESULT_HIGH, {ch, lv[5:2]});
      rd(ADCI_OFF_RESULT_LOW, {6'h0, lv[1:0]});
      wr(ADCI_OFF_CONTROL, {ch, 1'b0, k[1:0], 1'b0});
      rd(ADCI_OFF_CONTROL, {ch, 1'b1, k[1:0], 1'b0});
      wr(ADCI_OFF_IRQ_STATUS, 8'h01);
      rd(ADCI_OFF_IRQ_STATUS, 8'h00);
    end
    // Abort mid-conversion: no completion may follow
    wr(ADCI_OFF_CONTROL, 8'hA1);
    wr(ADCI_OFF_CONTROL, 8'hA0);
    repeat (80) @(posedge pclk);
    chk({32'h0, irq}, 33'h0, "irq after abort");
    rd(ADCI_OFF_CONTROL, 8'hA0);
    // Masked completion stays silent until unmasked
    wr(ADCI_OFF_IRQ_MASK, 8'h00);
    wr(ADCI_OFF_CONTROL, 8'h57);
    repeat (40) @(posedge pclk);
    chk({32'h0, irq}, 33'h0, "masked irq");
    rd(ADCI_OFF_IRQ_STATUS, 8'h01);
    wr(ADCI_OFF_IRQ_MASK, 8'h01);
    @(posedge pclk);
    chk({32'h0, irq}, 33'h1, "unmasked irq");
    wr(ADCI_OFF_IRQ_STATUS, 8'h01);
    @(posedge pclk);
    chk({32'h0, irq}, 33'h0, "cleared irq");
    rd(ADCI_OFF_CONTROL, 8'h5E);
    wrap_up();
  end
endmodule

// ---- adci_clkdiv.sv ----
// Conversion clock tick generator selected by the clock select code
module adci_clkdiv
  import adci_pkg::*;
(
  input  wire logic       pclk,
  input  wire logic       presetn,
  input  wire logic       run,
  input  wire logic [1:0] sel,
  output logic            tick
);
  logic [3:0] cnt_q;
  logic [3:0] last;

  always_comb begin
    unique case (sel)
      ADCI_DIV16: last = 4'hF;
      ADCI_DIV8:  last = 4'h7;
      ADCI_DIV4:  last = 4'h3;
      ADCI_DIV1:  last = 4'h0;
    endcase
  end

  // Counter parked while idle so every conversion starts phase-aligned
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cnt_q <= 4'h0;
    end else if (!run || cnt_q >= last) begin
      cnt_q <= 4'h0;
    end else begin
      cnt_q <= cnt_q + 4'h1;
    end
  end

  assign tick = run && (cnt_q >= last);

  a_div_period: assert property (@(posedge pclk) disable iff (!presetn)
    (run && sel == ADCI_DIV4 && tick) ##1 (run && sel == ADCI_DIV4)[*4] |-> tick)
    else $error("divide by 4 tick spacing wrong");
endmodule

// ---- adci_core_model.sv ----
// Behavioural model of the analog multiplexer and converter core
module adci_core_model
  import adci_pkg::*;
(
  input  wire logic                     pclk,
  input  wire logic [3:0]               channel_select,
  input  wire logic                     converter_enable,
  input  wire logic [5:0]               level,
  output logic [ADCI_RES_BITS-1:0]      core_sample
);
  initial core_sample = '0;
  // Idle core output toggles so a stale value is never mistaken for a result
  always @(posedge pclk) begin
    if (converter_enable) begin
      core_sample <= {channel_select, level};
    end else begin
      core_sample <= ~core_sample;
    end
  end
endmodule

// ---- adci_pkg.sv ----
// Package: register map, field layout and timing of the converter control block
package adci_pkg;
  localparam logic [11:0] ADCI_OFF_CONTROL     = 12'h344;
  localparam logic [11:0] ADCI_OFF_RESULT_HIGH = 12'h348;
  localparam logic [11:0] ADCI_OFF_RESULT_LOW  = 12'h34C;
  localparam logic [11:0] ADCI_OFF_IRQ_STATUS  = 12'h380;
  localparam logic [11:0] ADCI_OFF_IRQ_MASK    = 12'h384;
  localparam logic [7:0]  ADCI_IDX_CONTROL     = 8'hD1;
  localparam logic [7:0]  ADCI_IDX_RESULT_HIGH = 8'hD2;
  localparam logic [7:0]  ADCI_IDX_RESULT_LOW  = 8'hD3;
  localparam int          ADCI_CHAN_LSB        = 4;
  localparam int          ADCI_DONE_BIT        = 3;
  localparam int          ADCI_CLKSEL_LSB      = 1;
  localparam int          ADCI_START_BIT       = 0;
  localparam logic [7:0]  ADCI_CONTROL_RESET   = 8'h00;
  localparam logic [1:0]  ADCI_DIV16           = 2'h0;
  localparam logic [1:0]  ADCI_DIV8            = 2'h1;
  localparam logic [1:0]  ADCI_DIV4            = 2'h2;
  localparam logic [1:0]  ADCI_DIV1            = 2'h3;
  localparam int          ADCI_RES_BITS        = 10;
  localparam int          ADCI_CONV_TICKS      = 12;
  typedef enum logic [2:0] {
    ADCI_IDLE = 3'b001,
    ADCI_BUSY = 3'b010,
    ADCI_DONE = 3'b100
  } adci_state_t;
endpackage

// ---- adci_sequencer.sv ----
// Conversion sequencer: counts conversion clock ticks and hands back a result
module adci_sequencer
  import adci_pkg::*;
#(
  parameter int TICKS = ADCI_CONV_TICKS
) (
  input  wire logic                     pclk,
  input  wire logic                     presetn,
  input  wire logic                     start,
  input  wire logic                     tick,
  input  wire logic [ADCI_RES_BITS-1:0] sample,
  output logic                          busy,
  output logic                          done_pulse,
  output logic [ADCI_RES_BITS-1:0]      result
);
  adci_state_t state_q;
  logic [7:0]  cnt_q;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      state_q <= ADCI_IDLE;
      cnt_q   <= 8'h00;
    end else begin
      unique case (state_q)
        ADCI_IDLE: if (start) begin
          state_q <= ADCI_BUSY;
          cnt_q   <= 8'h00;
        end
        ADCI_BUSY: if (!start) begin
          state_q <= ADCI_IDLE;
        end else if (tick) begin
          if (cnt_q == 8'(TICKS - 1)) begin
            state_q <= ADCI_DONE;
          end
          cnt_q <= cnt_q + 8'h01;
        end
        ADCI_DONE: state_q <= ADCI_IDLE;
        default:   state_q <= ADCI_IDLE;
      endcase
    end
  end

  // Sample captured at the last tick, result presented with the done pulse
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      result <= '0;
    end else if (state_q == ADCI_BUSY && tick && cnt_q == 8'(TICKS - 1)) begin
      result <= sample;
    end
  end

  assign busy       = (state_q == ADCI_BUSY);
  assign done_pulse = (state_q == ADCI_DONE);
endmodule

// ---- adci_top.sv ----
// Converter control block: APB registers, conversion control and interrupt
module adci_top
  import adci_pkg::*;
#(
  parameter int TICKS = ADCI_CONV_TICKS
) (
  input  wire logic                     pclk,
  input  wire logic                     presetn,
  input  wire logic                     psel,
  input  wire logic                     penable,
  input  wire logic                     pwrite,
  input  wire logic [11:0]              paddr,
  input  wire logic [31:0]              pwdata,
  input  wire logic [3:0]               pstrb,
  output logic [31:0]                   prdata,
  output logic                          pready,
  output logic                          pslverr,
  input  wire logic [ADCI_RES_BITS-1:0] core_sample,
  output logic [3:0]                    channel_select,
  output logic                          converter_enable,
  output logic                          irq
);
  logic [3:0]               chan_q;
  logic [1:0]               clksel_q;
  logic                     start_q;
  logic                     done_q;
  logic [7:0]               result_high_q;
  logic [7:0]               result_low_q;
  logic                     irq_status_q;
  logic                     irq_mask_q;
  logic                     wr_en;
  logic                     rd_en;
  logic                     tick;
  logic                     busy;
  logic                     done_pulse;
  logic [ADCI_RES_BITS-1:0] result;
  logic [31:0]              prdata_d;
  logic                     mapped;

  function automatic logic addr_hit(input logic [11:0] a);
    addr_hit = (a == ADCI_OFF_CONTROL) || (a == ADCI_OFF_RESULT_HIGH) || (a == ADCI_OFF_RESULT_LOW)
            || (a == ADCI_OFF_IRQ_STATUS) || (a == ADCI_OFF_IRQ_MASK);
  endfunction

  assign mapped  = addr_hit(paddr);
  assign pready  = 1'b1;
  assign pslverr = psel && penable && !mapped;
  assign wr_en   = psel && penable && pwrite && mapped && pstrb[0];
  assign rd_en   = psel && penable && !pwrite;

  adci_clkdiv u_div (
    .pclk    (pclk),
    .presetn (presetn),
    .run     (busy),
    .sel     (clksel_q),
    .tick    (tick)
  );

  adci_sequencer #(.TICKS(TICKS)) u_seq (
    .pclk       (pclk),
    .presetn    (presetn),
    .start      (start_q),
    .tick       (tick),
    .sample     (core_sample),
    .busy       (busy),
    .done_pulse (done_pulse),
    .result     (result)
  );

  // Control fields; start bit self-clears when the conversion finishes
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      chan_q   <= ADCI_CONTROL_RESET[ADCI_CHAN_LSB +: 4];
      clksel_q <= ADCI_CONTROL_RESET[ADCI_CLKSEL_LSB +: 2];
      start_q  <= ADCI_CONTROL_RESET[ADCI_START_BIT];
    end else begin
      if (wr_en && paddr == ADCI_OFF_CONTROL) begin
        chan_q   <= pwdata[ADCI_CHAN_LSB +: 4];
        clksel_q <= pwdata[ADCI_CLKSEL_LSB +: 2];
        start_q  <= pwdata[ADCI_START_BIT];
      end else if (done_pulse) begin
        start_q <= 1'b0;
      end
    end
  end

  // Done flag clears on a fresh start and is never written directly
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      done_q <= ADCI_CONTROL_RESET[ADCI_DONE_BIT];
    end else if (done_pulse) begin
      done_q <= 1'b1;
    end else if (wr_en && paddr == ADCI_OFF_CONTROL && pwdata[ADCI_START_BIT]) begin
      done_q <= 1'b0;
    end
  end

  // Both bytes load together so a read after done is coherent
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      result_high_q <= 8'h00;
      result_low_q  <= 8'h00;
    end else if (done_pulse) begin
      result_high_q <= 8'(result >> 2);
      result_low_q  <= {6'h00, result[1:0]};
    end
  end

  // Sticky completion status, write one to clear; a new event wins
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      irq_status_q <= 1'b0;
    end else if (done_pulse) begin
      irq_status_q <= 1'b1;
    end else if (wr_en && paddr == ADCI_OFF_IRQ_STATUS && pwdata[0]) begin
      irq_status_q <= 1'b0;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      irq_mask_q <= 1'b0;
    end else if (wr_en && paddr == ADCI_OFF_IRQ_MASK) begin
      irq_mask_q <= pwdata[0];
    end
  end

  always_comb begin
    prdata_d = 32'h0000_0000;
    unique case (paddr)
      ADCI_OFF_CONTROL:     prdata_d[7:0] = {chan_q, done_q, clksel_q, start_q};
      ADCI_OFF_RESULT_HIGH: prdata_d[7:0] = result_high_q;
      ADCI_OFF_RESULT_LOW:  prdata_d[7:0] = result_low_q;
      ADCI_OFF_IRQ_STATUS:  prdata_d[0]   = irq_status_q;
      ADCI_OFF_IRQ_MASK:    prdata_d[0]   = irq_mask_q;
      default:              prdata_d      = 32'h0000_0000;
    endcase
  end

  // Read data registered in the setup cycle, valid in the access phase
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata <= 32'h0000_0000;
    end else if (psel && !penable && !pwrite) begin
      prdata <= prdata_d;
    end
  end

  assign channel_select   = chan_q;
  assign converter_enable = start_q;
  assign irq              = irq_status_q && irq_mask_q;

  a_done_loads_result: assert property (@(posedge pclk) disable iff (!presetn)
    done_pulse |=> done_q && result_high_q == 8'($past(result) >> 2)
      && result_low_q[1:0] == $past(result[1:0]))
    else $error("result not loaded with done flag");

  a_start_self_clear: assert property (@(posedge pclk) disable iff (!presetn)
    done_pulse && !(wr_en && paddr == ADCI_OFF_CONTROL) |=> !start_q)
    else $error("start bit did not self-clear");

  a_start_write: assert property (@(posedge pclk) disable iff (!presetn)
    wr_en && paddr == ADCI_OFF_CONTROL |=> start_q == $past(pwdata[0]) && chan_q == $past(pwdata[7:4]))
    else $error("control write not stored");

  a_done_readonly: assert property (@(posedge pclk) disable iff (!presetn)
    wr_en && paddr == ADCI_OFF_CONTROL && !pwdata[0] && !done_pulse |=> done_q == $past(done_q))
    else $error("done flag changed by write");

  a_result_ro: assert property (@(posedge pclk) disable iff (!presetn)
    wr_en && paddr == ADCI_OFF_RESULT_HIGH && !done_pulse |=> $stable(result_high_q))
    else $error("result high changed by write");

  a_chan_out: assert property (@(posedge pclk) disable iff (!presetn)
    channel_select == chan_q && chan_q == prdata_d[7:4] || paddr != ADCI_OFF_CONTROL)
    else $error("channel mismatch");

  a_disable_stops: assert property (@(posedge pclk) disable iff (!presetn)
    !start_q ##1 !start_q |-> !busy)
    else $error("converter busy while disabled");

  a_reset_zero: assert property (@(posedge pclk)
    $rose(presetn) |-> chan_q == 4'h0 && clksel_q == 2'h0 && !done_q && !start_q)
    else $error("control not zero after reset");
endmodule
